// *** hw/fsr_fault_regs.sv ***
/*
  Latched protection flags and control input readback for a three phase gate driver.
  Assumes detector outputs and control pins are asynchronous levels; register
  accesses come from the serial interface logic on sys_clk as single-cycle strobes.
  Every pin passes the two flip-flop synchroniser, so a flag sets on the third
  edge after its detector rises, and the readback shows pins two edges late.
  A detector still high when software clears its flag sets it again at once.
  Flags 0 to 2 (reset and temperature) are not kept here and read zero.
*/
// Functional notes
// - Driver kept off during pump undervoltage
// - Undervoltage flag latched, feeds status output
// - Bit 4 set on phase U counter trip
// - Bit 5 U ground short, disables U
// - Bit 6 U supply short, disables U
// - Bit 8 set on phase V counter trip
// - Bit 9 V ground short, disables V
// - Bit 10 V supply short, disables V
// - Bit 12 set on phase W counter trip
// - Bit 13 W ground short, disables W
// - Bit 14 W supply short, disables W
// - Offset 0x04 reads current control pins
// - Gate inputs bits 0-5, enable bit 6
// - Write one clears; enable toggle clears all
// - Bit 3 set on pump undervoltage
module fsr_fault_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control input pins: UL, UH, VL, VH, WL, WH
  input wire logic phase_u_low_input,
  input wire logic phase_u_high_input,
  input wire logic phase_v_low_input,
  input wire logic phase_v_high_input,
  input wire logic phase_w_low_input,
  input wire logic phase_w_high_input,
  input wire logic drv_en,
  // Protection detector levels, index 0 = U, 1 = V, 2 = W
  input wire logic pump_undervoltage,
  input wire logic [2:0] short_counter_trip,
  input wire logic [2:0] short_ground_detect,
  input wire logic [2:0] short_supply_detect,
  // Register access
  input wire logic [fsr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [fsr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [fsr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Protection outputs
  output logic status_out,
  output logic driver_disable,
  output logic [2:0] phase_disable
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [fsr_pkg::FLAG_W-1:0] flags;
    logic drv_en_prev;
    logic [1:0] warm;
    logic status;
    logic drv_off;
    logic [2:0] ph_off;
    logic [fsr_pkg::DATA_W-1:0] rdata;
    logic rvalid;
  } fsr_state_s;

  fsr_state_s state_q;
  fsr_state_s state_d;
  logic [fsr_pkg::SYNC_W-1:0] pins_sync;
  logic [fsr_pkg::FLAG_W-1:0] flag_set;
  logic [fsr_pkg::FLAG_W-1:0] flag_clr;
  logic [2:0] flag_set_ph [3];
  logic [fsr_pkg::FLAG_W-1:0] flag_set_all;
  logic wr_flags;
  logic rd_flags;
  logic rd_pins;
  logic en_cycled;

  function automatic logic addr_hit(input logic [fsr_pkg::ADDR_W-1:0] a, input logic [fsr_pkg::ADDR_W-1:0] r);
    addr_hit = (a == r);
  endfunction : addr_hit

  // Flag index of a phase's field, given where that field sits for phase U
  function automatic int phase_bit(input int base, input int ph);
    phase_bit = base + fsr_pkg::PHASE_STRIDE * ph;
  endfunction : phase_bit

  // Pin snapshot as software sees it: gates low, enable at its own bit
  function automatic logic [fsr_pkg::DATA_W-1:0] pin_word(input logic [fsr_pkg::SYNC_W-1:0] s);
    pin_word = '0;
    pin_word[fsr_pkg::GATE_W-1:0] = s[fsr_pkg::SY_GATES +: fsr_pkg::GATE_W];
    pin_word[fsr_pkg::DRV_EN_BIT] = s[fsr_pkg::SY_DRV_EN];
  endfunction : pin_word

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  fsr_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({short_supply_detect, short_ground_detect, short_counter_trip, pump_undervoltage, drv_en,
               phase_w_high_input, phase_w_low_input, phase_v_high_input, phase_v_low_input,
               phase_u_high_input, phase_u_low_input}),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // Flag set and clear terms
  // ----------------------------------------------------------------
  // Undervoltage is the only flag outside the per-phase groups
  always_comb begin
    flag_set = '0;
    flag_set[fsr_pkg::PUMP_UV_BIT] = pins_sync[fsr_pkg::SY_UV];
  end

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      // Detector levels re-set the flag while the fault persists
      assign flag_set_ph[p] = {pins_sync[fsr_pkg::SY_S2VS+p], pins_sync[fsr_pkg::SY_S2G+p],
                               pins_sync[fsr_pkg::SY_TRIP+p]};
    end
  endgenerate

  always_comb begin
    flag_set_all = flag_set;
    for (int i = 0; i < 3; i++) begin
      // Groups at bits 4, 8 and 12
      flag_set_all[phase_bit(fsr_pkg::SHORTDET_U_BIT, i) +: 3] = flag_set_ph[i];
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_flags = reg_wr && addr_hit(reg_addr, fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR);
  assign rd_flags = reg_rd && addr_hit(reg_addr, fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR);
  assign rd_pins = reg_rd && addr_hit(reg_addr, fsr_pkg::INPUT_PIN_READBACK_ADDR);

  // ----------------------------------------------------------------
  // Enable cycling
  // ----------------------------------------------------------------
  // Synchroniser and previous level both start at zero, so a pin already
  // high would look like an edge; compare only once both hold real levels
  assign en_cycled = (state_q.warm == fsr_pkg::EN_WARM_DONE)
                     && (pins_sync[fsr_pkg::SY_DRV_EN] != state_q.drv_en_prev);

  always_comb begin
    flag_clr = '0;
    if (wr_flags) begin
      flag_clr = reg_wdata[fsr_pkg::FLAG_W-1:0];
    end
    // Either edge of the enable pin counts as a cycle
    if (en_cycled) begin
      flag_clr = '1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.drv_en_prev = pins_sync[fsr_pkg::SY_DRV_EN];
    // Counts edges until the enable history holds real pin levels
    if (state_q.warm != fsr_pkg::EN_WARM_DONE) begin
      state_d.warm = state_q.warm + 2'h1;
    end
    // Set beats clear so a fault in the clearing cycle is kept
    state_d.flags = ((state_q.flags & ~flag_clr) | flag_set_all) & fsr_pkg::FLAG_MASK;
    // Built from the next flags so status moves with them
    state_d.status = |(state_d.flags & fsr_pkg::FLAG_MASK);
    // Live condition, not the flag: clearing the flag is not needed to restart
    state_d.drv_off = pins_sync[fsr_pkg::SY_UV];
    for (int i = 0; i < 3; i++) begin
      // Held off until software clears; the controller must also drop the gate input
      state_d.ph_off[i] = state_d.flags[phase_bit(fsr_pkg::SHORT_GROUND_U_BIT, i)]
                        | state_d.flags[phase_bit(fsr_pkg::SHORT_SUPPLY_U_BIT, i)];
    end
    state_d.rvalid = reg_rd;
    // Unmapped reads return zero rather than stale data
    if (reg_rd) begin
      state_d.rdata = '0;
    end
    if (rd_flags) begin
      state_d.rdata[fsr_pkg::FLAG_W-1:0] = state_q.flags;
    end
    if (rd_pins) begin
      state_d.rdata = pin_word(pins_sync);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.flags <= fsr_pkg::FLAGS_RESET;
      state_q.drv_en_prev <= 1'b0;
      state_q.warm <= 2'h0;
      state_q.status <= 1'b0;
      state_q.drv_off <= 1'b0;
      state_q.ph_off <= 3'h0;
      state_q.rdata <= fsr_pkg::RDATA_RESET;
      state_q.rvalid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register
  assign reg_rdata = state_q.rdata;
  assign reg_rvalid = state_q.rvalid;
  assign status_out = state_q.status;
  assign driver_disable = state_q.drv_off;
  assign phase_disable = state_q.ph_off;
endmodule : fsr_fault_regs

// *** hw/fsr_sync.sv ***
/*
  Two flip-flop synchroniser for a vector of unrelated levels.
  Assumes each bit is an independent level; no bus coherence is implied.
*/
module fsr_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [fsr_pkg::SYNC_W-1:0] async_in,
  output logic [fsr_pkg::SYNC_W-1:0] sync_out
);
  typedef struct packed {
    logic [fsr_pkg::SYNC_W-1:0] meta;
    logic [fsr_pkg::SYNC_W-1:0] stable;
  } fsr_sync_s;

  fsr_sync_s state_q;
  fsr_sync_s state_d;

  always_comb begin
    state_d.meta = async_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.meta <= fsr_pkg::SYNC_RESET;
      state_q.stable <= fsr_pkg::SYNC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;
endmodule : fsr_sync

// *** inc/fsr_pkg.sv ***
/*
  Constants for the fault status and input readback register bank.
  Assumes a 7-bit register address taken as a word index, as on the serial port.
*/
package fsr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 15;
  localparam logic [6:0] GLOBAL_FAULT_FLAGS_ADDR = 7'h01;
  localparam logic [6:0] INPUT_PIN_READBACK_ADDR = 7'h04;
  localparam logic [14:0] FLAGS_RESET = 15'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------
  localparam int PUMP_UV_BIT = 3;
  localparam int SHORTDET_U_BIT = 4;
  localparam int SHORT_GROUND_U_BIT = 5;
  localparam int SHORT_SUPPLY_U_BIT = 6;
  localparam int SHORTDET_V_BIT = 8;
  localparam int SHORT_GROUND_V_BIT = 9;
  localparam int SHORT_SUPPLY_V_BIT = 10;
  localparam int SHORTDET_W_BIT = 12;
  localparam int SHORT_GROUND_W_BIT = 13;
  localparam int SHORT_SUPPLY_W_BIT = 14;
  // Implemented flags; all of them feed the status output
  localparam logic [14:0] FLAG_MASK = 15'h7778;
  // Phase stride between the U, V and W flag groups
  localparam int PHASE_STRIDE = 4;

  // ----------------------------------------------------------------
  // Readback layout and pin synchroniser vector
  // ----------------------------------------------------------------
  localparam int GATE_W = 6;
  localparam int DRV_EN_BIT = 6;
  localparam int SYNC_W = 17;
  localparam int SY_GATES = 0;
  localparam int SY_DRV_EN = 6;
  localparam int SY_UV = 7;
  localparam int SY_TRIP = 8;
  localparam int SY_S2G = 11;
  localparam int SY_S2VS = 14;
  localparam logic [16:0] SYNC_RESET = 17'h00000;
  // Edges after reset before the enable pin history holds real levels
  localparam logic [1:0] EN_WARM_DONE = 2'h3;
endpackage : fsr_pkg

// *** sim/fsr_ctrl_model.sv ***
/*
  Motor controller model driving gate pins and the enable pin.
  Assumes the bench calls its tasks; pins change just after sys_clk edges.
*/
module fsr_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Pins toward the driver
  output logic [5:0] gates,
  output logic drv_en
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    gates = 6'h00;
    drv_en = 1'b1;
  end
  task automatic drive(input logic [5:0] g, input logic en);
    @(posedge sys_clk);
    gates <= g;
    drv_en <= en;
  endtask : drive
  // Shorted phase: both gates off first, a cleared flag alone restarts nothing
  task automatic release_phase(input int p);
    @(posedge sys_clk);
    gates[2*p +: 2] <= 2'b00;
  endtask : release_phase
endmodule : fsr_ctrl_model

// *** sim/fsr_fault_regs_properties.sv ***
/*
  Port assertions for the fault flag bank.
  Assumes one sys_clk domain; bound to every fsr_fault_regs.
*/
module fsr_fault_regs_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Inputs
  input wire logic pump_undervoltage,
  input wire logic [2:0] short_counter_trip,
  input wire logic [2:0] short_ground_detect,
  input wire logic [2:0] short_supply_detect,
  input wire logic [fsr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  // Outputs
  input wire logic [fsr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic status_out,
  input wire logic driver_disable,
  input wire logic [2:0] phase_disable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read valid");
  a_uv_disable: assert property (pump_undervoltage [*3] |=> driver_disable) else $error("driver not off");
  a_uv_status: assert property (pump_undervoltage [*3] |=> status_out) else $error("uv not on status");
  a_status_any: assert property (|phase_disable |-> status_out) else $error("status low with flag");
  a_ground_u: assert property ((short_ground_detect[0]) [*3] |=> phase_disable[0] && status_out)
    else $error("phase u not off");
  a_supply_v: assert property ((short_supply_detect[1]) [*3] |=> phase_disable[1]) else $error("phase v not off");
  a_ground_w: assert property ((short_ground_detect[2]) [*3] |=> phase_disable[2]) else $error("phase w not off");
  a_trip_v_status: assert property ((short_counter_trip[1]) [*3] |=> status_out) else $error("trip not on status");
  a_unused_zero: assert property (reg_rvalid && $past(reg_addr) == fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR |->
    !reg_rdata[7] && !reg_rdata[11] && reg_rdata[31:15] == 17'h00000) else $error("unused flag bit set");
  c_flag_write: cover property (reg_wr && reg_addr == fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR);
  c_drv_off: cover property (driver_disable);
  c_phase_off: cover property (phase_disable != 3'h0 && status_out);
endmodule : fsr_fault_regs_properties

bind fsr_fault_regs fsr_fault_regs_properties u_props (.*);

// *** sim/tb_top.sv ***
/*
  Self-checking bench for fsr_fault_regs.
  Assumes the controller model and the bound property checker.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] gates;
  logic drv_en;
  logic [9:0] det = 10'h000; // Supply, ground, trip, uv
  logic [6:0] reg_addr = 7'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, rd;
  logic reg_rvalid, status_out, driver_disable;
  logic [2:0] phase_disable;
  int n_errors = 0;
  int tests_run = 0;
  logic [6:0] pin_rows [8] = '{7'h41, 7'h42, 7'h44, 7'h48, 7'h50, 7'h60, 7'h3f, 7'h7f};
  int flag_pos [10] = '{3, 4, 8, 12, 5, 9, 13, 6, 10, 14};
  always #25 sys_clk = ~sys_clk;
  fsr_ctrl_model ctrl (.sys_clk(sys_clk), .gates(gates), .drv_en(drv_en));
  fsr_fault_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .phase_u_low_input(gates[0]), .phase_u_high_input(gates[1]),
    .phase_v_low_input(gates[2]), .phase_v_high_input(gates[3]), .phase_w_low_input(gates[4]),
    .phase_w_high_input(gates[5]), .drv_en(drv_en), .pump_undervoltage(det[0]), .short_counter_trip(det[3:1]),
    .short_ground_detect(det[6:4]), .short_supply_detect(det[9:7]), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .status_out(status_out), .driver_disable(driver_disable), .phase_disable(phase_disable));
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic reg_read(input logic [6:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("rvalid", {31'h0, reg_rvalid}, 32'h1);
    d = reg_rdata;
  endtask : reg_read
  task automatic reg_write(input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    check("status_rst", {31'h0, status_out}, 32'h0);
    rst_n <= 1'b1;
    foreach (pin_rows[i]) begin
      ctrl.drive(pin_rows[i][5:0], pin_rows[i][6]);
      repeat (3) @(posedge sys_clk);
      reg_read(fsr_pkg::INPUT_PIN_READBACK_ADDR, rd);
      check("readback", rd, {25'h0, pin_rows[i]});
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      det <= 10'h001 << i;
      repeat (4) @(posedge sys_clk);
      check("phase_dis", {29'h0, phase_disable}, (i > 3) ? 32'h1 << ((i - 4) % 3) : 32'h0);
      check("drv_dis", {31'h0, driver_disable}, (i == 0) ? 32'h1 : 32'h0);
      check("status_set", {31'h0, status_out}, 32'h1);
      det <= 10'h000;
      reg_read(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, rd);
      check("flags", rd, 32'h1 << flag_pos[i]);
      reg_write(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, 32'h1 << flag_pos[i]);
      reg_read(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, rd);
      check("cleared", rd, 32'h0);
      check("status_clr", {31'h0, status_out}, 32'h0);
    end
    // Clear while the short persists: set wins, unused bits stay zero
    ctrl.drive(6'h03, 1'b1);
    det <= 10'h010;
    repeat (4) @(posedge sys_clk);
    reg_write(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, 32'hffff_ffff);
    reg_read(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, rd);
    check("set_wins", rd, 32'h0000_0020);
    @(posedge sys_clk);
    det <= 10'h000;
    ctrl.release_phase(0);
    ctrl.drive(6'h00, 1'b0);
    repeat (4) @(posedge sys_clk);
    reg_read(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, rd);
    check("enable_clr", rd, 32'h0);
    check("pd_clr", {29'h0, phase_disable}, 32'h0);
    reg_read(7'h02, rd);
    check("unmapped", rd, 32'h0);
    // Reset in mid-run while a short is latched
    @(posedge sys_clk);
    det <= 10'h010;
    repeat (4) @(posedge sys_clk);
    check("pd_set", {29'h0, phase_disable}, 32'h1);
    rst_n <= 1'b0;
    det <= 10'h000;
    @(posedge sys_clk);
    check("pd_rst", {29'h0, phase_disable}, 32'h0);
    check("status_mid_rst", {31'h0, status_out}, 32'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reg_read(fsr_pkg::GLOBAL_FAULT_FLAGS_ADDR, rd);
    check("flags_rst", rd, 32'h0);
    give_verdict();
  end
endmodule : tb_top
